//--- rtl/pgp_pkg.sv
// Constants, register map and carrier types of the general pin pair
package pgp_pkg;

   // --------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------
   localparam logic [7:0] PIN_ONE_CONFIG_OFS   = 8'h12;
   localparam logic [7:0] PIN_TWO_CONFIG_OFS   = 8'h13;
   localparam logic [7:0] CHIP_CONFIG_CODE_OFS = 8'h14;

   // --------------------------------------------------------------
   // Pin configuration field positions
   // --------------------------------------------------------------
   localparam int DIR_POS   = 0;
   localparam int LEVEL_POS = 1;
   localparam int DRV_POS   = 2;
   localparam int DOUT_POS  = 3;
   localparam int DEB_POS   = 4;
   localparam int ALT_POS   = 5;

   // --------------------------------------------------------------
   // Chip code layout: top bit at 7, low nibble at 3:0
   // --------------------------------------------------------------
   localparam int CODE_HI_POS  = 7;
   localparam int CODE_BITS    = 5;

   // --------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------
   localparam logic DIR_RST  = 1'b1;
   localparam logic DRV_RST  = 1'b0;
   localparam logic DOUT_RST = 1'b0;
   localparam logic DEB_RST  = 1'b0;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // --------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------
   localparam int CLK_MHZ         = 100;
   localparam int DEBOUNCE_MS     = 30;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_MHZ * 1000;

   // --------------------------------------------------------------
   // Carrier types
   // --------------------------------------------------------------
   typedef struct packed {
      logic alt;
      logic deb;
      logic dout;
      logic drv;
      logic dir;
   } pgp_cfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } pgp_req_s;

endpackage

//--- rtl/pgp_pin_filter.sv
// Pin input synchroniser with optional debounce filter
`timescale 1ns/10ps
module pgp_pin_filter
#(
   parameter int DEBOUNCE_CYCLES = pgp_pkg::DEBOUNCE_CYCLES
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic nrst,
   // Pin and control
   input  wire logic pin_raw,
   input  wire logic deb_en,
   // Filtered level
   output logic      level
);

   localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(DEBOUNCE_CYCLES - 1);

   logic [2:0]    sync_q;
   logic          agreed_q;
   logic          level_q;
   logic [CW-1:0] cnt_q;

   // --------------------------------------------------------------
   // Synchroniser: a change counts once stages two and three agree
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         sync_q <= 3'h0;
      else
         sync_q <= {sync_q[1:0], pin_raw};
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         agreed_q <= 1'b0;
      else if (sync_q[1] == sync_q[2])
         agreed_q <= sync_q[2];
   end

   // --------------------------------------------------------------
   // Debounce
   // --------------------------------------------------------------
   // debounce or bypass
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         level_q <= 1'b0;
         cnt_q   <= '0;
      end
      else if (!deb_en || agreed_q == level_q)
      begin
         // Any bounce that reaches agreed_q restarts the full hold time
         level_q <= agreed_q;
         cnt_q   <= '0;
      end
      else if (cnt_q == LAST)
      begin
         level_q <= agreed_q;
         cnt_q   <= '0;
      end
      else
         cnt_q <= cnt_q + 1'b1;
   end

   assign level = level_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   chk_bypass_follows: assert property (
      !deb_en && agreed_q != level_q |=> level_q == $past(agreed_q))
      else $error("Undebounced level did not follow input");

   // Enable as seen at the edge that moved the level, not the one after
   chk_debounce_hold: assert property (
      $past(deb_en) && $changed(level_q) |-> $past(cnt_q) == LAST)
      else $error("Debounced level changed before hold time");

   cov_debounced_edge: cover property (deb_en && $changed(level_q));

endmodule

//--- rtl/pgp_gpio_pair.sv
// Configuration and readback of a pair of general pins plus chip code
// Contract
// - Direction bit 0 makes general output, 1 makes general input.
// - Drive type bit 0 selects open-drain, 1 selects push-pull.
// - Output data 0 drives low; 1 drives high or floats if open-drain.
// - In input direction output data and drive type have no effect.
// - Pin level bit 1 always reports the pin level, either direction.
// - Debounce enable 0 gives no filter; 1 gives a 30 ms filter.
// - First pin alternate bit 5 makes the pin second rail enable.
// - Second pin alternate bit makes the pin low-power bias enable.
// - Host writes zero to reserved bits 7:6; their reads mean nothing.
// - Read-only five-bit chip code, top bit 7, low bits 3:0.
`timescale 1ns/10ps
module pgp_gpio_pair
#(
   parameter int         DEBOUNCE_CYCLES = pgp_pkg::DEBOUNCE_CYCLES,
   parameter logic [1:0] ALT_RESET       = 2'h0,
   // Arbitrary neutral chip code
   parameter logic [4:0] CHIP_CODE       = 5'h0a
)
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Register access from the serial host port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Pins
   input  wire logic [1:0] pin_in,
   output logic      [1:0] pin_out,
   output logic      [1:0] pin_oe,
   // Alternate functions
   output logic            second_buck_boost_rail_enable,
   output logic            low_power_bias_enable
);

   pgp_pkg::pgp_cfg_s cfg_q [2];
   pgp_pkg::pgp_req_s req;
   logic [1:0]        level;
   logic [1:0]        out_q;
   logic [1:0]        oe_q;
   logic [7:0]        rdata_q;
   logic [7:0]        rdata_d;
   logic              rail_q;
   logic              bias_q;

   assign req = '{addr: reg_addr, wr: reg_wr, rd: reg_rd, wdata: reg_wdata};

   // --------------------------------------------------------------
   // Per pin: configuration, filter and driver
   // --------------------------------------------------------------
   for (genvar p = 0; p < 2; p++)
   begin : g_pin
      localparam logic [7:0] OFS = (p == 0) ? pgp_pkg::PIN_ONE_CONFIG_OFS
                                            : pgp_pkg::PIN_TWO_CONFIG_OFS;

      always_ff @(posedge ref_clk or negedge nrst)
      begin
         if (!nrst)
         begin
            cfg_q[p].alt  <= ALT_RESET[p];
            cfg_q[p].deb  <= pgp_pkg::DEB_RST;
            cfg_q[p].dout <= pgp_pkg::DOUT_RST;
            cfg_q[p].drv  <= pgp_pkg::DRV_RST;
            cfg_q[p].dir  <= pgp_pkg::DIR_RST;
         end
         else if (req.wr && req.addr == OFS)
         begin
            cfg_q[p].alt  <= req.wdata[pgp_pkg::ALT_POS];
            cfg_q[p].deb  <= req.wdata[pgp_pkg::DEB_POS];
            cfg_q[p].dout <= req.wdata[pgp_pkg::DOUT_POS];
            cfg_q[p].drv  <= req.wdata[pgp_pkg::DRV_POS];
            cfg_q[p].dir  <= req.wdata[pgp_pkg::DIR_POS];
         end
      end

      pgp_pin_filter #(
         .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
      ) u_filter (
         .ref_clk (ref_clk),
         .nrst    (nrst),
         .pin_raw (pin_in[p]),
         .deb_en  (cfg_q[p].deb),
         .level   (level[p])
      );

      // output only when direction is 0
      // input or alternate mode never drives
      // open-drain high releases, push-pull high drives
      always_ff @(posedge ref_clk or negedge nrst)
      begin
         if (!nrst)
         begin
            oe_q[p]  <= 1'b0;
            out_q[p] <= 1'b0;
         end
         else
         begin
            oe_q[p]  <= !cfg_q[p].alt && !cfg_q[p].dir &&
                        (cfg_q[p].drv || !cfg_q[p].dout);
            out_q[p] <= cfg_q[p].dout && cfg_q[p].drv;
         end
      end
   end

   // --------------------------------------------------------------
   // Alternate functions
   // --------------------------------------------------------------
   // first pin enables second rail
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rail_q <= 1'b0;
         bias_q <= 1'b0;
      end
      else
      begin
         rail_q <= cfg_q[0].alt && level[0];
         bias_q <= cfg_q[1].alt && level[1];
      end
   end

   // --------------------------------------------------------------
   // Read path
   // --------------------------------------------------------------
   function automatic logic [7:0] cfg_word(pgp_pkg::pgp_cfg_s c, logic lv);
      logic [7:0] w;
      w = 8'h00;
      w[pgp_pkg::ALT_POS]   = c.alt;
      w[pgp_pkg::DEB_POS]   = c.deb;
      w[pgp_pkg::DOUT_POS]  = c.dout;
      w[pgp_pkg::DRV_POS]   = c.drv;
      w[pgp_pkg::LEVEL_POS] = lv;
      w[pgp_pkg::DIR_POS]   = c.dir;
      return w;
   endfunction

   // chip code split over 7 and 3:0
   always_comb
   begin
      rdata_d = 8'h00;
      case (req.addr)
         pgp_pkg::PIN_ONE_CONFIG_OFS:   rdata_d = cfg_word(cfg_q[0], level[0]);
         pgp_pkg::PIN_TWO_CONFIG_OFS:   rdata_d = cfg_word(cfg_q[1], level[1]);
         pgp_pkg::CHIP_CONFIG_CODE_OFS:
            rdata_d = {CHIP_CODE[pgp_pkg::CODE_BITS-1], 3'h0, CHIP_CODE[3:0]};
         default:                       rdata_d = 8'h00;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= pgp_pkg::RDATA_RST;
      else if (req.rd)
         rdata_q <= rdata_d;
   end

   assign reg_rdata                     = rdata_q;
   assign pin_out                       = out_q;
   assign pin_oe                        = oe_q;
   assign second_buck_boost_rail_enable = rail_q;
   assign low_power_bias_enable         = bias_q;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   chk_input_floats: assert property (
      cfg_q[0].dir |=> !pin_oe[0])
      else $error("Input pin was driven");

   chk_ignore_output: assert property (
      cfg_q[1].dir && $changed(cfg_q[1].dout) |=> !pin_oe[1])
      else $error("Output data affected an input pin");

   chk_od_low: assert property (
      !cfg_q[0].alt && !cfg_q[0].dir && !cfg_q[0].dout
      |=> pin_oe[0] && !pin_out[0])
      else $error("Output low not driven");

   chk_od_release: assert property (
      !cfg_q[0].alt && !cfg_q[0].dir && !cfg_q[0].drv && cfg_q[0].dout
      |=> !pin_oe[0])
      else $error("Open-drain high was driven");

   chk_pp_high: assert property (
      !cfg_q[1].alt && !cfg_q[1].dir && cfg_q[1].drv && cfg_q[1].dout
      |=> pin_oe[1] && pin_out[1])
      else $error("Push-pull high not driven");

   chk_level_read: assert property (
      req.rd && req.addr == pgp_pkg::PIN_ONE_CONFIG_OFS
      |=> reg_rdata[pgp_pkg::LEVEL_POS] == $past(level[0]))
      else $error("Level bit does not match pin");

   chk_rsvd_zero: assert property (
      req.rd && req.addr == pgp_pkg::PIN_TWO_CONFIG_OFS
      |=> reg_rdata[7:6] == 2'h0)
      else $error("Reserved bits read nonzero");

   chk_code_read: assert property (
      req.rd && req.addr == pgp_pkg::CHIP_CONFIG_CODE_OFS
      |=> reg_rdata == {CHIP_CODE[4], 3'h0, CHIP_CODE[3:0]})
      else $error("Chip code read wrong");

   chk_rail_enable: assert property (
      cfg_q[0].alt |=> second_buck_boost_rail_enable == $past(level[0]))
      else $error("Rail enable does not follow pin");

   chk_bias_enable: assert property (
      !cfg_q[1].alt |=> !low_power_bias_enable)
      else $error("Bias enable without alternate mode");

   chk_alt_no_drive: assert property (
      cfg_q[1].alt |=> !pin_oe[1])
      else $error("Alternate input pin was driven");

   cov_od_output: cover property (pin_oe[0] && !pin_out[0]);
   cov_pp_output: cover property (pin_oe[1] && pin_out[1]);
   cov_rail_on:   cover property (second_buck_boost_rail_enable);
   cov_bias_on:   cover property (low_power_bias_enable);

endmodule

//--- testbench/pgp_pin_model.sv
// External circuit model: pull-up plus optional drivers on both pins
`timescale 1ns/10ps
module pgp_pin_model
(
   // From the device
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   // Bench control of the outside drivers
   input  wire logic [1:0] ext_en,
   input  wire logic [1:0] ext_val,
   // Resolved wire level
   output logic      [1:0] pin_lvl
);
   // ----------
   // Wire resolution
   // ----------
   // released pin follows the outside driver if enabled, else pulls high
   always_comb
   begin
      for (int i = 0; i < 2; i++)
         pin_lvl[i] = pin_oe[i] ? pin_out[i] :
                      (ext_en[i] ? ext_val[i] : 1'b1);
   end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the general pin pair
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [7:0] val;
      logic [7:0] msk;
   } pgp_exp_s;
   localparam logic [7:0] A_ONE  = pgp_pkg::PIN_ONE_CONFIG_OFS;
   localparam logic [7:0] A_TWO  = pgp_pkg::PIN_TWO_CONFIG_OFS;
   localparam logic [7:0] A_CODE = pgp_pkg::CHIP_CONFIG_CODE_OFS;
   // Arbitrary code, top bit set to exercise bit 7
   localparam logic [4:0] CODE   = 5'h15;
   localparam logic [7:0] XCODE  = {CODE[4], 3'h0, CODE[3:0]};
   logic       ref_clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic [1:0] pin_in;
   logic [1:0] pin_out;
   logic [1:0] pin_oe;
   logic [1:0] ext_en = 2'h0;
   logic [1:0] ext_val = 2'h0;
   logic       rail_en;
   logic       bias_en;
   logic       rd_d = 1'b0;
   logic [7:0] a;
   logic [7:0] v;
   int         fails = 0;
   int         comparisons = 0;
   int         seed = 52859;
   pgp_exp_s   expq[$];
   pgp_exp_s   e;

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   pgp_gpio_pair #(.DEBOUNCE_CYCLES(8), .ALT_RESET(2'h0), .CHIP_CODE(CODE))
   pgp_gpio_pair_inst (.ref_clk(ref_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe),
      .second_buck_boost_rail_enable(rail_en),
      .low_power_bias_enable(bias_en));

   pgp_pin_model pgp_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

   task automatic stop_test;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input pgp_exp_s x);
      comparisons++;
      if ((got & x.msk) !== (x.val & x.msk))
      begin
         fails++;
         $display("Error at %0t: read %h expected %h", $time, got, x.val);
      end
   endtask

   task automatic chk_pin(input logic [1:0] got, input logic [1:0] xp);
      comparisons++;
      if (got !== xp)
      begin
         fails++;
         $display("Error at %0t: pins %b expected %b", $time, got, xp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge ref_clk) #1;
      reg_addr = ad;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk) #1;
      reg_wr = 1'b0;
   endtask

   // Reserved bits are masked off: their reads carry no meaning
   task automatic rd(input logic [7:0] ad, input logic [7:0] xv,
                     input logic [7:0] m);
      @(posedge ref_clk) #1;
      reg_addr = ad;
      reg_rd = 1'b1;
      expq.push_back('{xv, m});
      @(posedge ref_clk) #1;
      reg_rd = 1'b0;
   endtask

   // ----------
   // Read monitor
   // ----------
   always @(posedge ref_clk) rd_d <= reg_rd;
   always @(negedge ref_clk)
   begin
      if (rd_d && expq.size() > 0)
      begin
         e = expq.pop_front();
         cmp(reg_rdata, e);
      end
   end

   initial
   begin
      #100000;
      fails++;
      stop_test();
   end

   initial
   begin
      repeat (8) @(posedge ref_clk);
      #1 nrst = 1'b1;
      idle(8);
      rd(A_ONE, 8'h03, 8'h3f);
      rd(A_TWO, 8'h03, 8'h3f);
      rd(A_CODE, XCODE, 8'h8f);
      wr(A_CODE, 8'hff);
      rd(A_CODE, XCODE, 8'h8f);
      rd(8'h20, 8'h00, 8'hff);
      for (int i = 0; i < 2; i++)
         for (int m = 0; m < 4; m++)
         begin
            a = A_ONE + 8'(i);
            wr(a, {4'h0, m[1], m[0], 2'h0});
            idle(2);
            chk_pin({pin_oe[i], pin_out[i]},
                    {m[0] | ~m[1], m[0] & m[1]});
            idle(6);
            rd(a, {4'h0, m[1], m[0], m[1], 1'b0}, 8'h3f);
         end
      ext_en = 2'h3;
      repeat (6)
      begin
         v = 8'($random(seed));
         ext_val = v[7:6];
         wr(A_ONE, {4'h0, v[3:2], 2'h1});
         wr(A_TWO, {4'h0, v[5:4], 2'h1});
         idle(8);
         chk_pin(pin_oe, 2'h0);
         rd(A_ONE, {4'h0, v[3:2], v[6], 1'b1}, 8'h3f);
         rd(A_TWO, {4'h0, v[5:4], v[7], 1'b1}, 8'h3f);
      end
      ext_val = 2'h3;
      wr(A_TWO, 8'h11);
      idle(20);
      // Short glitch must not pass the filter: read while it stands
      ext_val[1] = 1'b0;
      idle(4);
      rd(A_TWO, 8'h13, 8'h3f);
      ext_val[1] = 1'b1;
      idle(20);
      rd(A_TWO, 8'h13, 8'h3f);
      ext_val[1] = 1'b0;
      idle(20);
      rd(A_TWO, 8'h11, 8'h3f);
      for (int i = 0; i < 2; i++)
      begin
         a = A_ONE + 8'(i);
         wr(a, 8'h20);
         for (int k = 1; k >= 0; k--)
         begin
            ext_val[i] = k[0];
            idle(12);
            chk_pin({1'b0, pin_oe[i]}, 2'h0);
            chk_pin({rail_en, bias_en},
                    {k[0] & (i == 0), k[0] & (i == 1)});
            rd(a, {6'h08, k[0], 1'b0}, 8'h3f);
         end
         wr(a, 8'h01);
      end
      idle(4);
      stop_test();
   end
endmodule
